// ### rtl/aux_pin_device.sv
`timescale 1ns/1ns
module aux_pin_device
  import aux_gpio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  aux_gpio_if.device link,
  input wire logic conv_done,
  input wire logic [15:0] conv_data,
  output logic [7:0] pin_ctrl,
  output logic conversion_ready
);

  typedef enum logic [1:0] {
    ST_SYNC,
    ST_CMD,
    ST_WDATA,
    ST_DATA_LO
  } dev_state_t;

  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= link.pin_level;
      pin_sync_r <= pin_meta_r;
    end
  end

  // ****************************************
  // command decoder state
  // ****************************************
  dev_state_t state_r;
  dev_state_t state_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic ready_r;
  logic ready_nxt;
  logic [15:0] hold_r;
  logic [15:0] hold_nxt;
  logic rsp_valid_r;
  logic rsp_valid_nxt;
  logic [7:0] rsp_byte_r;
  logic [7:0] rsp_byte_nxt;
  logic [7:0] ctrl_view;
  logic write_hit;
  logic read_hit;
  logic data_read;

  // ****************************************
  // register view
  // ****************************************
  always_comb begin
    ctrl_view = ctrl_r;
    ctrl_view[BIT_RESERVED] = 1'b0;
    // an input pin reports the sensed level, not the stored bit
    ctrl_view[BIT_PIN2_LVL] = ctrl_r[BIT_PIN2_DIR] ? ctrl_r[BIT_PIN2_LVL] : pin_sync_r[2];
    ctrl_view[BIT_PIN1_LVL] = ctrl_r[BIT_PIN1_DIR] ? ctrl_r[BIT_PIN1_LVL] : pin_sync_r[1];
    ctrl_view[BIT_PIN0_LVL] = ctrl_r[BIT_PIN0_DIR] ? ctrl_r[BIT_PIN0_LVL] : pin_sync_r[0];
  end

  // ****************************************
  // command decode
  // ****************************************
  always_comb begin
    write_hit = (link.cmd_byte[7:4] == OP_WRITE_REG) && (link.cmd_byte[3:1] == PIN_CTRL_ADDR);
    read_hit = (link.cmd_byte[7:4] == OP_READ_REG) && (link.cmd_byte[3:1] == PIN_CTRL_ADDR);
    data_read = 1'b0;
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    hold_nxt = hold_r;
    rsp_valid_nxt = 1'b0;
    rsp_byte_nxt = rsp_byte_r;
    case (state_r)
      ST_SYNC: begin
        // anything but the sync word is dropped while idle
        if (link.cmd_valid && link.cmd_byte == SYNC_WORD) begin
          state_nxt = ST_CMD;
        end
      end
      ST_CMD: begin
        if (link.cmd_valid) begin
          // unknown commands fall back to waiting for sync
          state_nxt = ST_SYNC;
          if (write_hit) begin
            state_nxt = ST_WDATA;
          end else if (read_hit) begin
            rsp_valid_nxt = 1'b1;
            rsp_byte_nxt = ctrl_view;
          end else if (link.cmd_byte == CMD_READ_DATA) begin
            data_read = 1'b1;
            hold_nxt = conv_data;
            rsp_valid_nxt = 1'b1;
            rsp_byte_nxt = conv_data[15:8];
            state_nxt = ST_DATA_LO;
          end
        end
      end
      ST_WDATA: begin
        if (link.cmd_valid) begin
          // reserved bit dropped here so no read can ever see it set
          ctrl_nxt = link.cmd_byte;
          ctrl_nxt[BIT_RESERVED] = 1'b0;
          state_nxt = ST_SYNC;
        end
      end
      ST_DATA_LO: begin
        // low byte follows with no gap; the host cannot pause the pair
        rsp_valid_nxt = 1'b1;
        rsp_byte_nxt = hold_r[7:0];
        state_nxt = ST_SYNC;
      end
      default: begin
        state_nxt = ST_SYNC;
      end
    endcase
  end

  // ****************************************
  // conversion-ready flag
  // ****************************************
  // set wins: a result landing in the read cycle must not be lost
  always_comb begin
    ready_nxt = ready_r;
    if (conv_done) begin
      ready_nxt = 1'b1;
    end else if (data_read) begin
      ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  // ****************************************
  // decoder registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_SYNC;
      ctrl_r <= PIN_CTRL_RESET;
      hold_r <= 16'h0000;
      rsp_valid_r <= 1'b0;
      rsp_byte_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      hold_r <= hold_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_byte_r <= rsp_byte_nxt;
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  always_comb begin
    link.dev_pin_oe[2] = ctrl_r[BIT_PIN2_DIR];
    link.dev_pin_oe[1] = ctrl_r[BIT_PIN1_DIR];
    link.dev_pin_oe[0] = ctrl_r[BIT_PIN0_DIR];
    // pin 2 falls when a result waits to be read
    if (ctrl_r[BIT_PIN2_SRC]) begin
      link.dev_pin_out[2] = ~ready_r;
    end else begin
      link.dev_pin_out[2] = ctrl_r[BIT_PIN2_LVL];
    end
    // stored levels reach the pins only once oe turns on
    link.dev_pin_out[1] = ctrl_r[BIT_PIN1_LVL];
    link.dev_pin_out[0] = ctrl_r[BIT_PIN0_LVL];
  end

  // ****************************************
  // link and status outputs
  // ****************************************
  assign link.rsp_valid = rsp_valid_r;
  assign link.rsp_byte = rsp_byte_r;
  assign pin_ctrl = ctrl_view;
  assign conversion_ready = ready_r;

endmodule : aux_pin_device

// ### rtl/aux_pin_host.sv
// The strobed register port was decided locally.
`timescale 1ns/1ns
module aux_pin_host
  import aux_gpio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  aux_gpio_if.host link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_OP,
    H_ARG,
    H_WAIT_HI,
    H_WAIT_LO
  } host_state_t;

  // ****************************************
  // pin synchroniser and ready edge
  // ****************************************
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic pin2_old_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
      pin2_old_r <= 1'b0;
    end else begin
      pin_meta_r <= link.pin_level;
      pin_sync_r <= pin_meta_r;
      pin2_old_r <= pin_sync_r[2];
    end
  end

  // ****************************************
  // sequencer and registers
  // ****************************************
  host_state_t state_r, state_nxt;
  logic [1:0] op_r, op_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic cmd_valid_r, cmd_valid_nxt;
  logic [7:0] cmd_byte_r, cmd_byte_nxt;
  logic [7:0] readback_r, readback_nxt;
  logic [15:0] data_r, data_nxt;
  logic [2:0] status_r, status_nxt;
  logic [2:0] enable_r, enable_nxt;
  logic [5:0] pindrv_r, pindrv_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] events;

  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    wbyte_nxt = wbyte_r;
    cmd_valid_nxt = 1'b0;
    cmd_byte_nxt = cmd_byte_r;
    readback_nxt = readback_r;
    data_nxt = data_r;
    enable_nxt = enable_r;
    pindrv_nxt = pindrv_r;
    events = 3'h0;
    events[EV_READY_FALL] = pin2_old_r & ~pin_sync_r[2];
    case (state_r)
      H_IDLE: begin
        // commands written while busy are ignored
        if (wr && addr == HREG_CMD && wdata[1:0] != 2'h0) begin
          op_nxt = wdata[1:0];
          cmd_valid_nxt = 1'b1;
          cmd_byte_nxt = SYNC_WORD;
          state_nxt = H_OP;
        end
      end
      H_OP: begin
        cmd_valid_nxt = 1'b1;
        if (op_r == HOP_WRITE) begin
          cmd_byte_nxt = {OP_WRITE_REG, PIN_CTRL_ADDR, 1'b0};
          state_nxt = H_ARG;
        end else if (op_r == HOP_READ) begin
          cmd_byte_nxt = {OP_READ_REG, PIN_CTRL_ADDR, 1'b0};
          state_nxt = H_WAIT_HI;
        end else begin
          cmd_byte_nxt = CMD_READ_DATA;
          state_nxt = H_WAIT_HI;
        end
      end
      H_ARG: begin
        cmd_valid_nxt = 1'b1;
        cmd_byte_nxt = wbyte_r;
        cmd_byte_nxt[BIT_RESERVED] = 1'b0;
        state_nxt = H_IDLE;
      end
      H_WAIT_HI: begin
        if (link.rsp_valid) begin
          if (op_r == HOP_READ) begin
            readback_nxt = link.rsp_byte;
            events[EV_READ_DONE] = 1'b1;
            state_nxt = H_IDLE;
          end else begin
            data_nxt[15:8] = link.rsp_byte;
            state_nxt = H_WAIT_LO;
          end
        end
      end
      H_WAIT_LO: begin
        if (link.rsp_valid) begin
          data_nxt[7:0] = link.rsp_byte;
          events[EV_DATA_DONE] = 1'b1;
          state_nxt = H_IDLE;
        end
      end
      default: begin
        state_nxt = H_IDLE;
      end
    endcase
    if (wr && addr == HREG_WDATA) begin
      wbyte_nxt = wdata[7:0];
    end
    if (wr && addr == HREG_ENABLE) begin
      enable_nxt = wdata[2:0];
    end
    if (wr && addr == HREG_PINDRV) begin
      pindrv_nxt = {wdata[6:4], wdata[2:0]};
    end
    // set beats a clear in the same cycle
    status_nxt = status_r;
    if (wr && addr == HREG_CLEAR) begin
      status_nxt = status_r & ~wdata[2:0];
    end
    status_nxt = status_nxt | events;
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      case (addr)
        HREG_CMD: rdata_nxt = {31'h0, state_r != H_IDLE};
        HREG_WDATA: rdata_nxt = {24'h0, wbyte_r};
        HREG_READBACK: rdata_nxt = {24'h0, readback_r};
        HREG_DATA: rdata_nxt = {16'h0, data_r};
        HREG_STATUS: rdata_nxt = {29'h0, status_r};
        HREG_ENABLE: rdata_nxt = {29'h0, enable_r};
        HREG_PINDRV: rdata_nxt = {25'h0, pindrv_r[5:3], 1'b0, pindrv_r[2:0]};
        HREG_PINS: rdata_nxt = {29'h0, pin_sync_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= H_IDLE;
      op_r <= 2'h0;
      wbyte_r <= 8'h00;
      cmd_valid_r <= 1'b0;
      cmd_byte_r <= 8'h00;
      readback_r <= 8'h00;
      data_r <= 16'h0000;
      status_r <= 3'h0;
      enable_r <= 3'h0;
      pindrv_r <= 6'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      wbyte_r <= wbyte_nxt;
      cmd_valid_r <= cmd_valid_nxt;
      cmd_byte_r <= cmd_byte_nxt;
      readback_r <= readback_nxt;
      data_r <= data_nxt;
      status_r <= status_nxt;
      enable_r <= enable_nxt;
      pindrv_r <= pindrv_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign link.cmd_valid = cmd_valid_r;
  assign link.cmd_byte = cmd_byte_r;
  assign link.host_pin_oe = pindrv_r[5:3];
  assign link.host_pin_out = pindrv_r[2:0];
  assign rdata = rdata_r;
  assign irq = |(status_r & enable_r);

endmodule : aux_pin_host

// ### shared/aux_gpio_if.sv
`timescale 1ns/1ns
// ****************************************
// command link and three shared pins
// ****************************************
interface aux_gpio_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic [2:0] dev_pin_out;
  logic [2:0] dev_pin_oe;
  logic [2:0] host_pin_out;
  logic [2:0] host_pin_oe;
  logic [2:0] pin_level;

  // device drive wins; undriven pins read low (weak pull-down)
  assign pin_level = (dev_pin_oe & dev_pin_out) | (~dev_pin_oe & host_pin_oe & host_pin_out);

  modport device (
    input cmd_valid,
    input cmd_byte,
    input pin_level,
    output rsp_valid,
    output rsp_byte,
    output dev_pin_out,
    output dev_pin_oe
  );

  modport host (
    output cmd_valid,
    output cmd_byte,
    input pin_level,
    input rsp_valid,
    input rsp_byte,
    output host_pin_out,
    output host_pin_oe
  );
endinterface : aux_gpio_if

// ### shared/aux_gpio_pkg.sv
// ****************************************
// constants shared by both ends
// ****************************************
package aux_gpio_pkg;
  // link bytes
  localparam logic [7:0] SYNC_WORD = 8'h55;
  localparam logic [3:0] OP_WRITE_REG = 4'h4;
  localparam logic [3:0] OP_READ_REG = 4'h2;
  localparam logic [7:0] CMD_READ_DATA = 8'h10;
  localparam logic [2:0] PIN_CTRL_ADDR = 3'h4;
  localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
  // pin-control field positions
  localparam int BIT_RESERVED = 7;
  localparam int BIT_PIN2_DIR = 6;
  localparam int BIT_PIN1_DIR = 5;
  localparam int BIT_PIN0_DIR = 4;
  localparam int BIT_PIN2_SRC = 3;
  localparam int BIT_PIN2_LVL = 2;
  localparam int BIT_PIN1_LVL = 1;
  localparam int BIT_PIN0_LVL = 0;
  // host register offsets
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_WDATA = 8'h04;
  localparam logic [7:0] HREG_READBACK = 8'h08;
  localparam logic [7:0] HREG_DATA = 8'h0c;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  localparam logic [7:0] HREG_CLEAR = 8'h14;
  localparam logic [7:0] HREG_ENABLE = 8'h18;
  localparam logic [7:0] HREG_PINDRV = 8'h1c;
  localparam logic [7:0] HREG_PINS = 8'h20;
  // host command codes
  localparam logic [1:0] HOP_WRITE = 2'h1;
  localparam logic [1:0] HOP_READ = 2'h2;
  localparam logic [1:0] HOP_DATA = 2'h3;
  // host event bits
  localparam int EV_READ_DONE = 0;
  localparam int EV_DATA_DONE = 1;
  localparam int EV_READY_FALL = 2;
endpackage : aux_gpio_pkg

// ### test/adc_gpio_control_register_test.sv
`timescale 1ns/1ns
module adc_gpio_control_register_test;
  import aux_gpio_pkg::*;
  logic clk, rst_b, wr, rd, conv_done, conversion_ready, irq;
  logic [7:0] addr, pin_ctrl;
  logic [31:0] wdata, rdata;
  logic [15:0] conv_data;
  logic [2:0] dir, p;
  int bad_count = 0;
  int num_checks = 0;
  aux_gpio_if link();
  aux_pin_device aux_pin_device_i(.clk(clk), .rst_b(rst_b), .link(link), .conv_done(conv_done),
    .conv_data(conv_data), .pin_ctrl(pin_ctrl), .conversion_ready(conversion_ready));
  aux_pin_host aux_pin_host_i(.clk(clk), .rst_b(rst_b), .link(link), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  aux_gpio_props aux_gpio_props_i(.clk(clk), .rst_b(rst_b), .cmd_valid(link.cmd_valid),
    .cmd_byte(link.cmd_byte), .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte),
    .dev_pin_out(link.dev_pin_out), .dev_pin_oe(link.dev_pin_oe));
  // ****************************************
  // access tasks
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_raw(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_raw
  task rd_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd_raw(a, v);
    check(v, exp);
  endtask : rd_reg
  // busy poll is bounded so a stuck link ends as a mismatch
  task op(input logic [1:0] c);
    logic [31:0] v;
    int n;
    wr_reg(HREG_CMD, {30'h0, c});
    n = 0;
    do begin
      rd_raw(HREG_CMD, v);
      n++;
    end while (v[0] !== 1'b0 && n < 50);
    check({31'h0, v[0]}, 32'h0);
  endtask : op
  task wctl(input logic [7:0] d);
    wr_reg(HREG_WDATA, {24'h0, d});
    op(HOP_WRITE);
  endtask : wctl
  task rctl(input logic [7:0] exp);
    op(HOP_READ);
    rd_reg(HREG_READBACK, {24'h0, exp});
  endtask : rctl
  task irq_is(input logic exp);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is
  task conclude;
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: run timed out", $time);
    conclude();
  end
  initial begin
    rst_b = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    conv_done = 1'b0;
    conv_data = 16'hbeef;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rctl(PIN_CTRL_RESET);
    check({29'h0, link.dev_pin_oe}, 32'h0);
    check({24'h0, pin_ctrl}, {24'h0, PIN_CTRL_RESET});
    wr_reg(HREG_ENABLE, 32'h7);
    // host drives 101 on all pins; device drive must win where it is an output
    wr_reg(HREG_PINDRV, 32'h75);
    for (int k = 0; k < 8; k++) begin
      dir = k[2:0];
      p = (dir & (dir ^ 3'h3)) | (~dir & 3'h5);
      wctl({1'b1, dir, 1'b0, dir ^ 3'h3});
      rctl({1'b0, dir, 1'b0, p});
      check({24'h0, pin_ctrl}, {24'h0, 1'b0, dir, 1'b0, p});
      rd_reg(HREG_PINS, {29'h0, p});
    end
    wr_reg(HREG_PINDRV, 32'h0);
    wctl(8'h48);
    check({24'h0, pin_ctrl}, 32'h48);
    rd_reg(HREG_PINS, 32'h4);
    wr_reg(HREG_CLEAR, 32'h7);
    rd_reg(HREG_STATUS, 32'h0);
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge clk);
    check({31'h0, conversion_ready}, 32'h1);
    rd_reg(HREG_PINS, 32'h0);
    rd_reg(HREG_STATUS, 32'h4);
    irq_is(1'b1);
    op(HOP_DATA);
    rd_reg(HREG_DATA, 32'h0000beef);
    check({31'h0, conversion_ready}, 32'h0);
    rd_reg(HREG_PINS, 32'h4);
    rd_reg(HREG_STATUS, 32'h6);
    wr_reg(HREG_ENABLE, 32'h1);
    irq_is(1'b0);
    wr_reg(HREG_ENABLE, 32'h7);
    irq_is(1'b1);
    wr_reg(HREG_CLEAR, 32'h6);
    irq_is(1'b0);
    rd_reg(HREG_STATUS, 32'h0);
    rd_reg(HREG_CLEAR, 32'h0);
    rd_reg(8'h40, 32'h0);
    // second reset in mid-run must drop every pin back to input
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1 check({29'h0, link.dev_pin_oe}, 32'h0);
    rctl(PIN_CTRL_RESET);
    conclude();
  end
endmodule : adc_gpio_control_register_test

// ### test/aux_gpio_props.sv
`timescale 1ns/1ns
module aux_gpio_props
  import aux_gpio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic [2:0] dev_pin_out,
  input wire logic [2:0] dev_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // link sequences
  // ****************************************
  // a data byte equal to the sync word must not count as a sync
  sequence sync_s;
    !cmd_valid ##1 cmd_valid && cmd_byte == SYNC_WORD;
  endsequence
  sequence wr_s;
    sync_s ##1 cmd_valid && cmd_byte[7:4] == OP_WRITE_REG && cmd_byte[3:1] == PIN_CTRL_ADDR
      ##1 cmd_valid;
  endsequence
  sequence rd_s;
    sync_s ##1 cmd_valid && cmd_byte[7:4] == OP_READ_REG && cmd_byte[3:1] == PIN_CTRL_ADDR;
  endsequence
  sequence data_s;
    sync_s ##1 cmd_valid && cmd_byte == CMD_READ_DATA;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  chk_reset_inputs: assert property ($rose(rst_b) |-> dev_pin_oe == 3'h0)
    else $error("pins driven after reset");
  chk_sync_then_cmd: assert property (sync_s |=> cmd_valid && cmd_byte != SYNC_WORD)
    else $error("sync word not followed by a command");
  chk_pin_dirs: assert property (wr_s |=> dev_pin_oe == $past(cmd_byte[6:4]))
    else $error("pin directions differ from written byte");
  chk_pin_levels: assert property (wr_s |=>
    (dev_pin_out[1:0] & dev_pin_oe[1:0]) == ($past(cmd_byte[1:0]) & $past(cmd_byte[5:4])))
    else $error("pin 0 or 1 level differs from written byte");
  chk_pin2_level: assert property (wr_s ##0 (cmd_byte[6] && !cmd_byte[3]) |=>
    dev_pin_out[2] == $past(cmd_byte[2]))
    else $error("pin 2 level differs from written byte");
  chk_read_answer: assert property (rd_s |=> rsp_valid && !rsp_byte[7])
    else $error("register read answer late or bit 7 set");
  chk_data_pair: assert property (data_s |=> rsp_valid [*2] ##1 !rsp_valid)
    else $error("data read not answered by two bytes");
  chk_rsp_cause: assert property (rsp_valid |-> $past(cmd_valid) || $past(cmd_valid, 2))
    else $error("answer without a command");
  cover property (wr_s);
  cover property (rd_s);
  cover property (data_s ##1 rsp_valid [*2]);
endmodule : aux_gpio_props
